// ### design/sts_pkg.sv
// shared constants, types and state records of the sweep trigger sequencer
package sts_pkg;
   // register bus geometry
   localparam int AW = 8;
   localparam int DW = 32;
   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_CMD = 8'h04;
   localparam logic [AW-1:0] OFS_START = 8'h08;
   localparam logic [AW-1:0] OFS_STOP = 8'h0C;
   localparam logic [AW-1:0] OFS_STEP = 8'h10;
   localparam logic [AW-1:0] OFS_DWELL = 8'h14;
   localparam logic [AW-1:0] OFS_TDLY = 8'h18;
   localparam logic [AW-1:0] OFS_STATUS = 8'h1C;
   localparam logic [AW-1:0] OFS_POINTS = 8'h20;
   localparam logic [AW-1:0] OFS_FREQ = 8'h24;
   // command register bit positions (write only, self clearing)
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_TRG_BIT = 1;
   localparam int CMD_ABORT_BIT = 2;
   // least start/stop separation for a swept span, in Hz
   localparam logic [DW-1:0] MIN_SPAN_HZ = 32'h0000_0002;
   // divider iteration count
   localparam logic [5:0] DIV_STEPS = 6'h20;
   // sweep modes
   typedef enum logic [1:0] {
      MODE_LIST = 2'h0,
      MODE_RAMP = 2'h1,
      MODE_STEP = 2'h2
   } sts_mode_e;
   // point advance sources
   typedef enum logic [1:0] {
      point_advance_self_timed = 2'h0,
      point_advance_remote_source = 2'h1,
      point_advance_external_source = 2'h2
   } sts_pt_e;
   // sweep start sources
   typedef enum logic [1:0] {
      START_AUTO = 2'h0,
      START_BUS = 2'h1,
      START_EXT = 2'h2
   } sts_start_e;
   // sequencer states, gray along idle-arm-lock-delay-dwell-wait
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ARM = 3'h1,
      ST_LOCK = 3'h3,
      ST_DELAY = 3'h2,
      ST_DWELL = 3'h6,
      ST_WAIT = 3'h7
   } sts_state_e;
   // control register layout
   typedef struct packed {
      logic cont;
      sts_start_e start_src;
      sts_pt_e pt_src;
      sts_mode_e mode;
   } sts_ctrl_s;
   localparam int CTRL_W = 7;
   localparam sts_ctrl_s CTRL_RST = '{1'b0, START_AUTO, point_advance_self_timed, MODE_RAMP};
   // synchroniser state
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sts_sync_s;
   // divider state
   typedef struct packed {
      logic busy;
      logic [5:0] cnt;
      logic [DW:0] rem;
      logic [DW-1:0] quo;
      logic [DW-1:0] den;
      logic [DW-1:0] res;
   } sts_div_s;
   // sequencer core state
   typedef struct packed {
      sts_state_e st;
      sts_ctrl_s ctrl;
      logic [DW-1:0] start_f;
      logic [DW-1:0] stop_f;
      logic [DW-1:0] step;
      logic [DW-1:0] dwell;
      logic [DW-1:0] post_lock_output_pulse_delay;
      logic [DW-1:0] freq;
      logic [DW-1:0] idx;
      logic [DW-1:0] cnt;
      logic [DW-1:0] rdata;
      logic div_go;
      logic trig_out;
      logic srq;
   } sts_core_s;
endpackage

// ### design/sts_trig_sync.sv
// two-flop synchroniser with rising edge detector for a pin input
`timescale 1ns/1ps
module sts_trig_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous pin
   input wire logic pin,
   // synchronised level and one-cycle leading edge
   output logic level,
   output logic rise
);
   sts_pkg::sts_sync_s s_r; // all state
   sts_pkg::sts_sync_s s_nxt; // next state

   // shift chain; s1 feeds only s2, edge uses s2 and s3
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pin;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.s2;
   // a long pulse still yields one edge only
   assign rise = s_r.s2 & ~s_r.s3;
endmodule

// ### design/sts_div.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module sts_div (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request
   input wire logic go,
   input wire logic [sts_pkg::DW-1:0] num,
   input wire logic [sts_pkg::DW-1:0] den,
   // answer
   output logic busy,
   output logic [sts_pkg::DW-1:0] quo
);
   sts_pkg::sts_div_s s_r; // all state
   sts_pkg::sts_div_s s_nxt; // next state
   logic [sts_pkg::DW:0] sh; // remainder with next dividend bit

   // one iteration per cycle; a new go restarts a running division
   always_comb begin
      s_nxt = s_r;
      sh = {s_r.rem[sts_pkg::DW-1:0], s_r.quo[sts_pkg::DW-1]};
      if (go) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = '0;
         s_nxt.rem = '0;
         s_nxt.quo = num;
         s_nxt.den = den;
      end else if (s_r.busy) begin
         s_nxt.quo = {s_r.quo[sts_pkg::DW-2:0], 1'b0};
         // zero divisor gives all ones, a sweep that never ends by count
         if (sh >= {1'b0, s_r.den}) begin
            sh = sh - {1'b0, s_r.den};
            s_nxt.quo[0] = 1'b1;
         end
         s_nxt.rem = sh;
         s_nxt.cnt = s_r.cnt + 6'h01;
         if (s_nxt.cnt == sts_pkg::DIV_STEPS) begin
            s_nxt.busy = 1'b0;
            s_nxt.res = s_nxt.quo;
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign quo = s_r.res;
endmodule

// ### design/sts_core.sv
// sweep trigger sequencer: stepped sweep point and start control
// Behaviour
// RQ1: remote trigger advances point when source remote
// RQ2: external trigger advances point when source external
// RQ3: leading edge only, one advance per pulse
// RQ4: continuous sweep wraps to start after last
// RQ5: swept only while span at least 2 Hz
// RQ6: start equals stop gives zero span
// RQ7: automatic start begins sweep at once
// RQ8: bus start waits for remote trigger
// RQ9: external start waits for external trigger
// RQ10: after lock wait delay, pulse trigger out
// RQ11: settled request raised with trigger out
// RQ12: one of list, ramp, step modes
// RQ13: self timed advance after dwell plus lock
// RQ14: point count is span over step size
// RQ15: step from start toward stop by step
// RQ16: single sweep ends after last point
`timescale 1ns/1ps
module sts_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [sts_pkg::AW-1:0] addr,
   input wire logic [sts_pkg::DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [sts_pkg::DW-1:0] rdata,
   // pins
   input wire logic ext_trig_in,
   input wire logic phase_locked,
   // synthesiser and analyzer side
   output logic [sts_pkg::DW-1:0] freq_out,
   output logic [2:0] mode_sel,
   output logic zero_span,
   output logic sweeping,
   output logic trig_out,
   output logic srq_settled
);
   sts_pkg::sts_core_s s_r; // all state
   sts_pkg::sts_core_s s_nxt; // next state
   logic ext_rise; // external trigger leading edge
   logic locked; // synchronised lock level
   logic div_busy; // point count being computed
   logic [sts_pkg::DW-1:0] points; // step count from span over step
   logic [sts_pkg::DW-1:0] span; // unsigned start/stop separation
   logic down; // stop below start
   logic swept_ok; // span wide enough for a sweep
   logic bus_trg; // remote trigger command this cycle
   logic go; // single or continuous command this cycle
   logic abort; // stop sweep command
   logic pt_evt; // point advance event for chosen source
   logic start_evt; // sweep start event for chosen source
   logic adv; // point advance taken
   logic last; // current point is the final one

   // register write decode, used for several strobes
   function automatic logic wr_hit(input logic [sts_pkg::AW-1:0] ofs);
      return wr && (addr == ofs);
   endfunction

   // external trigger edge, immune to pulse length
   sts_trig_sync u_ext (
      .clk(clk),
      .rst(rst),
      .pin(ext_trig_in),
      .level(),
      .rise(ext_rise) // see RQ3
   );

   // lock indicator level
   sts_trig_sync u_lock (
      .clk(clk),
      .rst(rst),
      .pin(phase_locked),
      .level(locked),
      .rise()
   );

   // point count divider, restarted on any span or step change
   sts_div u_div (
      .clk(clk),
      .rst(rst),
      .go(s_r.div_go), // see RQ14
      .num(span),
      .den(s_r.step),
      .busy(div_busy),
      .quo(points)
   );

   // span checks and event decode
   always_comb begin
      down = s_r.stop_f < s_r.start_f;
      span = down ? s_r.start_f - s_r.stop_f : s_r.stop_f - s_r.start_f;
      swept_ok = span >= sts_pkg::MIN_SPAN_HZ; // see RQ5
      bus_trg = wr_hit(sts_pkg::OFS_CMD) && wdata[sts_pkg::CMD_TRG_BIT];
      go = wr_hit(sts_pkg::OFS_CMD) && wdata[sts_pkg::CMD_GO_BIT];
      abort = wr_hit(sts_pkg::OFS_CMD) && wdata[sts_pkg::CMD_ABORT_BIT];
      case (s_r.ctrl.pt_src)
         sts_pkg::point_advance_remote_source: pt_evt = bus_trg; // see RQ1
         sts_pkg::point_advance_external_source: pt_evt = ext_rise; // see RQ2
         default: pt_evt = 1'b1; // self timed: dwell already served, see RQ13
      endcase
      case (s_r.ctrl.start_src)
         sts_pkg::START_BUS: start_evt = bus_trg; // see RQ8
         sts_pkg::START_EXT: start_evt = ext_rise; // see RQ9
         default: start_evt = 1'b1; // see RQ7
      endcase
      adv = (s_r.st == sts_pkg::ST_WAIT) && pt_evt;
      last = s_r.idx >= points;
   end

   // next state: registers, sequencer and read mux
   always_comb begin
      s_nxt = s_r;
      s_nxt.trig_out = 1'b0;
      s_nxt.srq = 1'b0;
      s_nxt.div_go = wr_hit(sts_pkg::OFS_START) || wr_hit(sts_pkg::OFS_STOP)
         || wr_hit(sts_pkg::OFS_STEP);
      // register writes
      if (wr_hit(sts_pkg::OFS_CTRL)) begin
         s_nxt.ctrl = sts_pkg::sts_ctrl_s'(wdata[sts_pkg::CTRL_W-1:0]);
      end
      if (wr_hit(sts_pkg::OFS_START)) begin
         s_nxt.start_f = wdata;
      end
      if (wr_hit(sts_pkg::OFS_STOP)) begin
         s_nxt.stop_f = wdata;
      end
      if (wr_hit(sts_pkg::OFS_STEP)) begin
         s_nxt.step = wdata;
      end
      if (wr_hit(sts_pkg::OFS_DWELL)) begin
         s_nxt.dwell = wdata;
      end
      if (wr_hit(sts_pkg::OFS_TDLY)) begin
         s_nxt.post_lock_output_pulse_delay = wdata;
      end
      // sequencer
      case (s_r.st)
         sts_pkg::ST_IDLE: begin
            // triggers ignored here, see RQ16; zero span never sweeps, see RQ6
            if (go && swept_ok && s_r.ctrl.mode == sts_pkg::MODE_STEP) begin
               s_nxt.st = sts_pkg::ST_ARM;
               s_nxt.freq = s_r.start_f; // see RQ15
               s_nxt.idx = '0;
            end
         end
         sts_pkg::ST_ARM: begin
            if (start_evt) begin // see RQ7
               s_nxt.st = sts_pkg::ST_LOCK;
            end
         end
         sts_pkg::ST_LOCK: begin
            // lock time counts as part of the self timed interval
            // limitation: the lock level lags the pin by two flops, so a synthesiser
            // must already show unlock when the new point frequency is applied
            if (locked) begin
               s_nxt.st = sts_pkg::ST_DELAY;
               s_nxt.cnt = '0;
            end
         end
         sts_pkg::ST_DELAY: begin
            if (s_r.cnt >= s_r.post_lock_output_pulse_delay) begin // see RQ10
               s_nxt.trig_out = 1'b1;
               s_nxt.srq = 1'b1; // see RQ11
               s_nxt.st = sts_pkg::ST_DWELL;
               s_nxt.cnt = '0;
            end else begin
               s_nxt.cnt = s_r.cnt + 32'h0000_0001;
            end
         end
         sts_pkg::ST_DWELL: begin
            if (s_r.cnt >= s_r.dwell) begin // see RQ13
               s_nxt.st = sts_pkg::ST_WAIT;
            end else begin
               s_nxt.cnt = s_r.cnt + 32'h0000_0001;
            end
         end
         sts_pkg::ST_WAIT: begin
            if (adv && last && s_r.ctrl.cont) begin
               s_nxt.freq = s_r.start_f; // see RQ4
               s_nxt.idx = '0;
               s_nxt.st = sts_pkg::ST_LOCK;
            end else if (adv && last) begin
               s_nxt.st = sts_pkg::ST_IDLE; // see RQ16
            end else if (adv) begin
               s_nxt.freq = down ? s_r.freq - s_r.step : s_r.freq + s_r.step; // see RQ15
               s_nxt.idx = s_r.idx + 32'h0000_0001;
               s_nxt.st = sts_pkg::ST_LOCK;
            end
         end
         default: s_nxt.st = sts_pkg::ST_IDLE;
      endcase
      // abort, leaving the swept span, or leaving step mode ends any sweep
      if (abort || !swept_ok || s_r.ctrl.mode != sts_pkg::MODE_STEP) begin
         s_nxt.st = sts_pkg::ST_IDLE; // see RQ5
      end
      // read data, valid the cycle after the strobe; unmapped reads zero
      s_nxt.rdata = '0;
      if (rd) begin
         case (addr)
            sts_pkg::OFS_CTRL: s_nxt.rdata = {25'h0, s_r.ctrl};
            sts_pkg::OFS_START: s_nxt.rdata = s_r.start_f;
            sts_pkg::OFS_STOP: s_nxt.rdata = s_r.stop_f;
            sts_pkg::OFS_STEP: s_nxt.rdata = s_r.step;
            sts_pkg::OFS_DWELL: s_nxt.rdata = s_r.dwell;
            sts_pkg::OFS_TDLY: s_nxt.rdata = s_r.post_lock_output_pulse_delay;
            sts_pkg::OFS_STATUS: s_nxt.rdata = {25'h0, locked, div_busy,
               s_r.st != sts_pkg::ST_IDLE, !swept_ok, s_r.st};
            sts_pkg::OFS_POINTS: s_nxt.rdata = points;
            sts_pkg::OFS_FREQ: s_nxt.rdata = s_r.freq;
            default: s_nxt.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= sts_pkg::CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs
   assign rdata = s_r.rdata;
   assign freq_out = s_r.freq;
   assign trig_out = s_r.trig_out;
   assign srq_settled = s_r.srq;
   assign zero_span = !swept_ok; // see RQ6
   assign sweeping = s_r.st != sts_pkg::ST_IDLE;
   // exactly one mode line; an unused code falls back to ramp
   assign mode_sel = (s_r.ctrl.mode == sts_pkg::MODE_LIST) ? 3'h1 :
      (s_r.ctrl.mode == sts_pkg::MODE_STEP) ? 3'h4 : 3'h2; // see RQ12

   // checks
   // armed with automatic start, the sweep leaves arm on the very next edge
   sequence seq_arm_to_lock;
      s_r.st == sts_pkg::ST_ARM ##1 s_r.st == sts_pkg::ST_LOCK;
   endsequence
   // the pulse pair stands one cycle, as dwell begins
   sequence seq_pulse_pair;
      trig_out && srq_settled && s_r.st == sts_pkg::ST_DWELL ##1 !trig_out && !srq_settled;
   endsequence
   property p_auto_start;
      @(posedge clk) disable iff (rst)
      s_r.st == sts_pkg::ST_IDLE && go && swept_ok && !abort
         && s_r.ctrl.mode == sts_pkg::MODE_STEP && s_r.ctrl.start_src == sts_pkg::START_AUTO
         |=> seq_arm_to_lock;
   endproperty
   // with no delay the pulse follows the first delay cycle
   property p_delay_pulse;
      @(posedge clk) disable iff (rst)
      $rose(s_r.st == sts_pkg::ST_DELAY) && !abort && swept_ok
         && s_r.ctrl.mode == sts_pkg::MODE_STEP && s_r.post_lock_output_pulse_delay == '0
         |=> seq_pulse_pair;
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("auto start late"); // see RQ7
   a_trig_delay: assert property (p_delay_pulse) else $error("trigger out late"); // see RQ10
   // request and trigger form one pulse pair
   a_srq_pair: assert property (@(posedge clk) disable iff (rst) // see RQ11
      trig_out == srq_settled) else $error("settled request apart");
   // start triggers are taken only in arm
   a_bus_hold: assert property (@(posedge clk) disable iff (rst) // see RQ8
      s_r.st == sts_pkg::ST_ARM && s_r.ctrl.start_src == sts_pkg::START_BUS && !bus_trg
      && !abort |=> s_r.st == sts_pkg::ST_ARM || s_r.st == sts_pkg::ST_IDLE)
      else $error("bus start early");
   a_ext_hold: assert property (@(posedge clk) disable iff (rst) // see RQ9
      s_r.st == sts_pkg::ST_ARM && s_r.ctrl.start_src == sts_pkg::START_EXT && !ext_rise
      |=> s_r.st != sts_pkg::ST_LOCK) else $error("ext start early");
   // one pin pulse yields one edge
   a_edge_once: assert property (@(posedge clk) disable iff (rst) // see RQ3
      ext_rise |=> !ext_rise) else $error("double edge");
   // last point: wrap in continuous, end in single
   a_cont_wrap: assert property (@(posedge clk) disable iff (rst) // see RQ4
      adv && last && s_r.ctrl.cont && !abort && swept_ok && s_r.ctrl.mode == sts_pkg::MODE_STEP
      |=> freq_out == $past(s_r.start_f) && s_r.idx == '0) else $error("no wrap");
   a_single_end: assert property (@(posedge clk) disable iff (rst) // see RQ16
      adv && last && !s_r.ctrl.cont |=> !sweeping) else $error("single not ended");
   // an upward step moves by the step size
   a_step_inc: assert property (@(posedge clk) disable iff (rst) // see RQ15
      adv && !last && !down |=> freq_out == $past(s_r.freq) + $past(s_r.step))
      else $error("bad step");
   // zero span never sweeps
   a_zero_span: assert property (@(posedge clk) disable iff (rst) // see RQ6
      !swept_ok |=> !sweeping) else $error("zero span swept");
   a_mode_one: assert property (@(posedge clk) disable iff (rst) // see RQ12
      $onehot(mode_sel)) else $error("mode not one hot");
   // point triggers are taken only in wait
   a_remote_pt: assert property (@(posedge clk) disable iff (rst) // see RQ1
      s_r.st == sts_pkg::ST_WAIT && s_r.ctrl.pt_src == sts_pkg::point_advance_remote_source
      && !bus_trg && !abort |=> s_r.st == sts_pkg::ST_WAIT || s_r.st == sts_pkg::ST_IDLE)
      else $error("remote point early");
   a_ext_pt: assert property (@(posedge clk) disable iff (rst) // see RQ2
      s_r.st == sts_pkg::ST_WAIT && s_r.ctrl.pt_src == sts_pkg::point_advance_external_source
      && !ext_rise && !abort |=> s_r.st == sts_pkg::ST_WAIT || s_r.st == sts_pkg::ST_IDLE)
      else $error("external point early");
   // self timed points never linger in wait
   a_self_adv: assert property (@(posedge clk) disable iff (rst) // see RQ13
      s_r.st == sts_pkg::ST_WAIT && s_r.ctrl.pt_src == sts_pkg::point_advance_self_timed
      |=> s_r.st != sts_pkg::ST_WAIT) else $error("self timed point stuck");
endmodule

// ### tb/sts_far_model.sv
// far side model: external trigger source and synthesiser lock indicator
`timescale 1ns/1ps
module sts_far_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench controls
   input wire logic pulse_req,
   input wire logic [7:0] pulse_len,
   input wire logic [7:0] lock_lag,
   // watched frequency
   input wire logic [sts_pkg::DW-1:0] freq_out,
   // pins toward the block
   output logic ext_trig_in,
   output logic phase_locked
);
   logic [7:0] pulse_cnt_r; // cycles left in the trigger pulse
   logic [7:0] lock_cnt_r; // cycles left before lock returns
   logic [sts_pkg::DW-1:0] last_freq_r; // frequency seen last cycle
   // pulse held for its whole length, so a level-sensitive block would misbehave
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_cnt_r <= 8'h00;
      end else if (pulse_req) begin
         pulse_cnt_r <= pulse_len;
      end else if (pulse_cnt_r != 8'h00) begin
         pulse_cnt_r <= pulse_cnt_r - 8'h01;
      end
   end
   assign ext_trig_in = (pulse_cnt_r != 8'h00);
   // any frequency change drops lock for lock_lag cycles, zero means prompt
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_cnt_r <= 8'h00;
         last_freq_r <= '0;
      end else begin
         last_freq_r <= freq_out;
         if (freq_out != last_freq_r) begin
            lock_cnt_r <= lock_lag;
         end else if (lock_cnt_r != 8'h00) begin
            lock_cnt_r <= lock_cnt_r - 8'h01;
         end
      end
   end
   assign phase_locked = (lock_cnt_r == 8'h00);
endmodule

// ### tb/tb_top.sv
// self-checking bench of the sweep trigger sequencer
`timescale 1ns/1ps
module tb_top;
   logic clk; // system clock
   logic rst; // async reset
   logic [sts_pkg::AW-1:0] addr; // register address
   logic [sts_pkg::DW-1:0] wdata; // register write data
   logic wr; // write strobe
   logic rd; // read strobe
   logic [sts_pkg::DW-1:0] rdata; // read data
   logic ext_trig_in; // trigger pin
   logic phase_locked; // lock pin
   logic [sts_pkg::DW-1:0] freq_out; // point frequency
   logic [2:0] mode_sel; // one-hot mode
   logic zero_span; // span below minimum
   logic sweeping; // sequencer busy
   logic trig_out; // analyzer trigger
   logic srq_settled; // settled request
   logic pulse_req; // asks the model for a pin pulse
   logic [7:0] pulse_len; // pin pulse length
   logic [7:0] lock_lag; // relock time of the model
   int mismatches; // failed compares
   int n_checks; // compares made
   int n; // counted cycles or pulses
   logic [sts_pkg::DW-1:0] rv; // last read value

   sts_core uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ext_trig_in(ext_trig_in), .phase_locked(phase_locked),
      .freq_out(freq_out), .mode_sel(mode_sel), .zero_span(zero_span),
      .sweeping(sweeping), .trig_out(trig_out), .srq_settled(srq_settled));
   sts_far_model far (.clk(clk), .rst(rst), .pulse_req(pulse_req), .pulse_len(pulse_len),
      .lock_lag(lock_lag), .freq_out(freq_out), .ext_trig_in(ext_trig_in),
      .phase_locked(phase_locked));

   // free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle register write
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   // one-cycle register read, data taken the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rv = rdata;
   endtask

   // bounded wait for the next output trigger; request must come with it
   task automatic wait_trig(input int lim);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (trig_out !== 1'b1 && n < lim);
      chk(trig_out, 32'h1);
      chk(srq_settled, 32'h1);
   endtask

   // count output triggers over a span
   task automatic count_trig(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1;
         if (trig_out === 1'b1) n++;
      end
   endtask

   // ask the model for one pin pulse
   task automatic fire(input logic [7:0] len);
      @(posedge clk);
      pulse_len <= len;
      pulse_req <= 1'b1;
      @(posedge clk);
      pulse_req <= 1'b0;
   endtask

   // program a sweep, then give the point divider time to finish
   task automatic setup(input logic [31:0] f0, f1, stp, dw, dl, ct);
      wr_reg(sts_pkg::OFS_CTRL, ct);
      wr_reg(sts_pkg::OFS_START, f0);
      wr_reg(sts_pkg::OFS_STOP, f1);
      wr_reg(sts_pkg::OFS_STEP, stp);
      wr_reg(sts_pkg::OFS_DWELL, dw);
      wr_reg(sts_pkg::OFS_TDLY, dl);
      repeat (40) @(posedge clk);
   endtask

   // reset values and unmapped places
   task automatic t_reset;
      chk(32'(mode_sel), 32'h2);
      chk(zero_span, 32'h1);
      chk(sweeping, 32'h0);
      rd_reg(sts_pkg::OFS_CTRL);
      chk(rv, 32'h1);
      rd_reg(8'h40);
      chk(rv, 32'h0);
      rd_reg(sts_pkg::OFS_CMD);
      chk(rv, 32'h0);
   endtask

   // every mode once, then span limits around the 2 Hz minimum
   task automatic t_span;
      for (int m = 0; m < 3; m++) begin
         wr_reg(sts_pkg::OFS_CTRL, 32'(m));
         chk(32'(mode_sel), 32'h1 << m);
      end
      wr_reg(sts_pkg::OFS_START, 32'h3E8);
      wr_reg(sts_pkg::OFS_STOP, 32'h3E9);
      chk(zero_span, 32'h1);
      wr_reg(sts_pkg::OFS_STOP, 32'h3EA);
      chk(zero_span, 32'h0);
      wr_reg(sts_pkg::OFS_STOP, 32'h3E6);
      chk(zero_span, 32'h0);
      wr_reg(sts_pkg::OFS_STOP, 32'h3E8);
      chk(zero_span, 32'h1);
      wr_reg(sts_pkg::OFS_CMD, 32'h1);
      repeat (5) @(posedge clk);
      #1;
      chk(sweeping, 32'h0);
   endtask

   // self-timed single sweep, automatic start, slow relock
   task automatic t_auto;
      lock_lag <= 8'h04;
      setup(32'h64, 32'h82, 32'hA, 32'h2, 32'h1, 32'h02);
      rd_reg(sts_pkg::OFS_POINTS);
      chk(rv, 32'h3);
      wr_reg(sts_pkg::OFS_CMD, 32'h1);
      chk(sweeping, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wait_trig(80);
         chk(freq_out, 32'h64 + 32'(i) * 32'hA);
      end
      count_trig(60);
      chk(32'(n), 32'h0);
      chk(sweeping, 32'h0);
   endtask

   // remote start and remote point advance, continuous with wrap
   task automatic t_bus;
      lock_lag <= 8'h00;
      setup(32'h64, 32'h82, 32'hA, 32'h0, 32'h3, 32'h56);
      wr_reg(sts_pkg::OFS_CMD, 32'h1);
      count_trig(20);
      chk(32'(n), 32'h0);
      chk(sweeping, 32'h1);
      wr_reg(sts_pkg::OFS_CMD, 32'h2);
      wait_trig(40);
      // one lock cycle, then delay plus one cycles in delay
      chk(32'(n), 32'h5);
      chk(freq_out, 32'h64);
      for (int i = 1; i < 5; i++) begin
         count_trig(8);
         chk(32'(n), 32'h0);
         wr_reg(sts_pkg::OFS_CMD, 32'h2);
         wait_trig(40);
         chk(freq_out, (i == 4) ? 32'h64 : 32'h64 + 32'(i) * 32'hA);
      end
      wr_reg(sts_pkg::OFS_CMD, 32'h4);
      @(posedge clk);
      #1;
      chk(sweeping, 32'h0);
   endtask

   // external start and external point advance, single sweep, long start pulse then short point pulses
   task automatic t_ext;
      setup(32'h64, 32'h78, 32'hA, 32'h0, 32'h0, 32'h2A);
      wr_reg(sts_pkg::OFS_CMD, 32'h1);
      count_trig(20);
      chk(32'(n), 32'h0);
      fire(8'd30);
      count_trig(60);
      chk(32'(n), 32'h1);
      chk(freq_out, 32'h64);
      for (int i = 1; i < 3; i++) begin
         fire(8'd3);
         wait_trig(40);
         chk(freq_out, 32'h64 + 32'(i) * 32'hA);
      end
      fire(8'd3);
      count_trig(30);
      chk(32'(n), 32'h0);
      chk(sweeping, 32'h0);
      chk(freq_out, 32'h78);
   endtask

   // counts, verdict and end of run
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      mismatches = 0;
      n_checks = 0;
      rst = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      pulse_req = 1'b0;
      pulse_len = 8'h00;
      lock_lag = 8'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset;
      t_span;
      t_auto;
      t_bus;
      t_ext;
      final_report;
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      mismatches++;
      final_report;
   end
endmodule
